// ==== include/pwc_defs.svh ====
/*
 Constants of the periodic wakeup counter: register offsets, field positions,
 reset values. Assumes a 32-bit APB with one aligned word per register.
*/
`ifndef PWC_DEFS_SVH
`define PWC_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define PWC_OFS_STATUS_CONTROL 4'h0
`define PWC_OFS_COUNT_VALUE    4'h4
`define PWC_OFS_MATCH_LIMIT    4'h8
`define PWC_ADDR_W             4

// ----------------------------------------
// Status/control fields
// ----------------------------------------
`define PWC_BIT_MATCH_FLAG     7
`define PWC_SRC_HI             6
`define PWC_SRC_LO             5
`define PWC_BIT_IRQ_ENABLE     4
`define PWC_PS_HI              3
`define PWC_PS_LO              0

// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define PWC_RST_SRC            2'h0
`define PWC_RST_PS             4'h0
`define PWC_RST_BYTE           8'h00
`define PWC_PRESC_W            18
`define PWC_SRC_COUNT          3

`endif

// ==== include/pwc_pkg.sv ====
/*
 Types of the periodic wakeup counter. Assumes pwc_defs.svh is not needed here.
*/
package pwc_pkg;
   typedef enum {
      PWC_BUS_IDLE,
      PWC_BUS_ANSWER
   } pwc_bus_state_t;
endpackage

// ==== hdl/pwc_tick_sync.sv ====
/*
 Brings the raw counting clocks into the system clock domain and turns each
 rising edge into a one-cycle tick. Assumes each source is much slower than clk.
*/
`timescale 1ns/1ps
module pwc_tick_sync #(
   parameter int N = 3
) (
   input  wire logic         clk,
   input  wire logic         srst,
   input  wire logic [N-1:0] rawClk,
   output logic      [N-1:0] tick
);
   // ----------------------------------------
   // Two-stage synchroniser and edge detect
   // ----------------------------------------
   logic [N-1:0] meta_reg;
   logic [N-1:0] sync_reg;
   logic [N-1:0] last_reg;

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gSrc
         always_ff @(posedge clk) begin
            if (srst) begin
               meta_reg[g] <= 1'b0;
               sync_reg[g] <= 1'b0;
               last_reg[g] <= 1'b0;
            end else begin
               meta_reg[g] <= rawClk[g];
               sync_reg[g] <= meta_reg[g];
               last_reg[g] <= sync_reg[g];
            end
         end
         // Only the second stage feeds the edge detector
         assign tick[g] = sync_reg[g] & ~last_reg[g];
      end
   endgenerate
endmodule

// ==== hdl/periodic_wakeup_counter.sv ====
/*
 Periodic wakeup counter: 8-bit up-counter with prescaler, modulo match,
 sticky match flag, interrupt request and wakeup, behind an APB slave.
 Assumes the three counting clocks arrive as pins from other domains and the
 power-mode and debug inputs come from logic on clk.
*/
`timescale 1ns/1ps
`include "pwc_defs.svh"
module periodic_wakeup_counter (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        lowPowerOscClock,
   input  wire logic        externalRefClock,
   input  wire logic        internalRefClock,
   input  wire logic        waitMode,
   input  wire logic        stop2Mode,
   input  wire logic        stop3Mode,
   input  wire logic        debugActive,
   output logic             matchIrq,
   output logic             wakeup
);
   // ----------------------------------------
   // Divide value of a prescale setting
   // ----------------------------------------
   function automatic logic [`PWC_PRESC_W-1:0] divideOf(input logic lowSrc,
                                                        input logic [3:0] sel);
      logic [`PWC_PRESC_W-1:0] d;
      d = 18'h00000;
      if (!lowSrc) begin
         unique case (sel)
            4'h0: d = 18'h00000;
            4'h1: d = 18'h00008;
            4'h2: d = 18'h00020;
            4'h3: d = 18'h00040;
            4'h4: d = 18'h00080;
            4'h5: d = 18'h00100;
            4'h6: d = 18'h00200;
            4'h7: d = 18'h00400;
            4'h8: d = 18'h00001;
            4'h9: d = 18'h00002;
            4'hA: d = 18'h00004;
            4'hB: d = 18'h0000A;
            4'hC: d = 18'h00010;
            4'hD: d = 18'h00064;
            4'hE: d = 18'h001F4;
            4'hF: d = 18'h003E8;
         endcase
      end else begin
         unique case (sel)
            4'h0: d = 18'h00000;
            4'h1: d = 18'h00400;
            4'h2: d = 18'h00800;
            4'h3: d = 18'h01000;
            4'h4: d = 18'h02000;
            4'h5: d = 18'h04000;
            4'h6: d = 18'h08000;
            4'h7: d = 18'h10000;
            4'h8: d = 18'h003E8;
            4'h9: d = 18'h007D0;
            4'hA: d = 18'h01388;
            4'hB: d = 18'h02710;
            4'hC: d = 18'h04E20;
            4'hD: d = 18'h0C350;
            4'hE: d = 18'h186A0;
            4'hF: d = 18'h30D40;
         endcase
      end
      return d;
   endfunction

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   pwc_pkg::pwc_bus_state_t busState_reg;
   logic [31:0]              prdata_reg;
   logic                     pslverr_reg;
   logic                     pready_reg;
   logic                     flag_reg;
   logic [1:0]               srcSel_reg;
   logic                     irqEn_reg;
   logic [3:0]               psSel_reg;
   logic [7:0]               limit_reg;
   logic [7:0]               count_reg;
   logic [`PWC_PRESC_W-1:0]  presc_reg;
   logic                     matchIrq_reg;
   logic                     wakeup_reg;

   // ----------------------------------------
   // Clock source ticks
   // ----------------------------------------
   logic [`PWC_SRC_COUNT-1:0] srcTick;

   // Pins from foreign clocks cross here before anything reads them
   pwc_tick_sync #(
      .N (`PWC_SRC_COUNT)
   ) uTickSync (
      .clk    (clk),
      .srst   (srst),
      .rawClk ({internalRefClock, externalRefClock, lowPowerOscClock}),
      .tick   (srcTick)
   );

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   wire [`PWC_ADDR_W-1:0] ofs       = paddr[`PWC_ADDR_W-1:0];
   wire                   upperZero = (paddr[31:`PWC_ADDR_W] == 28'h0000000);
   wire                   hitSc     = upperZero && (ofs == `PWC_OFS_STATUS_CONTROL);
   wire                   hitCnt    = upperZero && (ofs == `PWC_OFS_COUNT_VALUE);
   wire                   hitLim    = upperZero && (ofs == `PWC_OFS_MATCH_LIMIT);
   wire                   mapped    = hitSc || hitCnt || hitLim;
   wire                   accessEnd = psel && penable && (busState_reg == pwc_pkg::PWC_BUS_ANSWER);
   wire                   busWrite  = accessEnd && pwrite;
   wire                   scWrite   = busWrite && hitSc;
   wire                   limWrite  = busWrite && hitLim; // count offset has no write path
   wire [1:0]             newSrc    = pwdata[`PWC_SRC_HI:`PWC_SRC_LO];
   wire [3:0]             newPs     = pwdata[`PWC_PS_HI:`PWC_PS_LO];
   wire                   clrWrite  = scWrite && pwdata[`PWC_BIT_MATCH_FLAG];
   wire                   selChange = scWrite && ((newSrc != srcSel_reg) || (newPs != psSel_reg));
   wire                   restart   = limWrite || selChange;

   wire [7:0] scValue = {flag_reg, srcSel_reg, irqEn_reg, psSel_reg};
   wire [7:0] rdByte  = hitSc  ? scValue :
                        hitCnt ? count_reg :
                        hitLim ? limit_reg : `PWC_RST_BYTE;

   // ----------------------------------------
   // Counting path
   // ----------------------------------------
   // 00 low-power, 01 external, 1x internal
   wire [1:0] srcIdx   = srcSel_reg[1] ? 2'h2 : {1'b0, srcSel_reg[0]};
   wire       tickSel  = srcTick[srcIdx];
   // Only the low-power source survives stop2
   wire       srcAlive = (srcSel_reg == 2'h0) || !stop2Mode;
   wire [`PWC_PRESC_W-1:0] divide = divideOf(srcSel_reg[0], psSel_reg);
   wire       running  = (divide != 18'h00000);
   // Debug freezes both counters in place
   wire       tickOk    = tickSel && srcAlive && running && !debugActive;
   wire       prescDone = tickOk && (presc_reg == divide - 18'h00001);
   // Limit zero keeps the count at zero and matches every prescaler edge
   wire       matchEvt  = prescDone && (count_reg == limit_reg);
   wire       flagNext  = matchEvt || (flag_reg && !clrWrite);

   // ----------------------------------------
   // APB slave
   // ----------------------------------------
   // Answer one cycle into the access phase; read data is captured then
   always_ff @(posedge clk) begin
      if (srst) begin
         busState_reg <= pwc_pkg::PWC_BUS_IDLE;
         prdata_reg   <= 32'h00000000;
         pslverr_reg  <= 1'b0;
         pready_reg   <= 1'b0;
      end else begin
         unique case (busState_reg)
            pwc_pkg::PWC_BUS_IDLE: begin
               if (psel && penable) begin
                  busState_reg <= pwc_pkg::PWC_BUS_ANSWER;
                  prdata_reg   <= {24'h000000, rdByte};
                  pslverr_reg  <= !mapped;
                  pready_reg   <= 1'b1;
               end
            end
            pwc_pkg::PWC_BUS_ANSWER: begin
               busState_reg <= pwc_pkg::PWC_BUS_IDLE;
               pslverr_reg  <= 1'b0;
               pready_reg   <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         flag_reg   <= 1'b0;
         srcSel_reg <= `PWC_RST_SRC;
         irqEn_reg  <= 1'b0;
         psSel_reg  <= `PWC_RST_PS;
         limit_reg  <= `PWC_RST_BYTE;
      end else begin
         flag_reg <= flagNext;
         if (scWrite) begin
            srcSel_reg <= newSrc;
            irqEn_reg  <= pwdata[`PWC_BIT_IRQ_ENABLE];
            psSel_reg  <= newPs;
         end
         if (limWrite) begin
            limit_reg <= pwdata[7:0];
         end
      end
   end

   // ----------------------------------------
   // Prescaler and counter
   // ----------------------------------------
   // Keeps running in wait and stop3 whenever a source tick arrives; in stop2 only on the low-power source
   always_ff @(posedge clk) begin
      if (srst || restart) begin
         presc_reg <= 18'h00000;
         count_reg <= `PWC_RST_BYTE;
      end else if (tickOk) begin
         if (prescDone) begin
            presc_reg <= 18'h00000;
            count_reg <= matchEvt ? 8'h00 : count_reg + 8'h01;
         end else begin
            presc_reg <= presc_reg + 18'h00001;
         end
      end
   end

   // ----------------------------------------
   // Interrupt request and wakeup
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         matchIrq_reg <= 1'b0;
         wakeup_reg   <= 1'b0;
      end else begin
         matchIrq_reg <= flag_reg && irqEn_reg;
         wakeup_reg   <= flag_reg && irqEn_reg && (waitMode || stop2Mode || stop3Mode);
      end
   end

   assign prdata   = prdata_reg;
   // Own flop, so the answer carries no decode glitch
   assign pready   = pready_reg;
   assign pslverr  = pslverr_reg;
   assign matchIrq = matchIrq_reg;
   assign wakeup   = wakeup_reg;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_wrapped;
      (count_reg == 8'h00) && flag_reg;
   endsequence
   sequence s_restarted;
      (count_reg == 8'h00) && (presc_reg == 18'h00000);
   endsequence

   property p_match_wrap;
      matchEvt && !restart |=> s_wrapped;
   endproperty
   a_match_wrap: assert property (p_match_wrap) else $error("no wrap on match");

   property p_increment;
      prescDone && !matchEvt && !restart |=> count_reg == $past(count_reg) + 8'h01;
   endproperty
   a_increment: assert property (p_increment) else $error("count did not step");

   property p_freeze;
      debugActive && !restart |=> $stable(count_reg) && $stable(presc_reg);
   endproperty
   a_freeze: assert property (p_freeze) else $error("count moved in debug");

   property p_clear_one;
      clrWrite && !matchEvt |=> !flag_reg;
   endproperty
   a_clear_one: assert property (p_clear_one) else $error("flag not cleared");

   property p_zero_keeps;
      flag_reg && !clrWrite |=> flag_reg;
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("flag lost");

   property p_restart;
      restart |=> s_restarted;
   endproperty
   a_restart: assert property (p_restart) else $error("restart missed");

   property p_irq;
      flag_reg && irqEn_reg ##1 flag_reg && irqEn_reg |-> matchIrq_reg;
   endproperty
   a_irq: assert property (p_irq) else $error("request missing");

   property p_stop2_hold;
      stop2Mode && (srcSel_reg != 2'h0) && !restart |=> $stable(presc_reg);
   endproperty
   a_stop2_hold: assert property (p_stop2_hold) else $error("counted in stop2");

   property p_zero_limit;
      prescDone && (limit_reg == 8'h00) |=> flag_reg;
   endproperty
   a_zero_limit: assert property (p_zero_limit) else $error("zero limit no flag");
endmodule

// ==== test/tb_top.sv ====
/*
 Self-checking bench for the periodic wakeup counter: APB register access,
 counting, match flag, interrupt, wakeup, debug freeze, source and divider
 selection. Assumes the design's own assertions and the defines header.
*/
`timescale 1ns/1ps
`include "pwc_defs.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top;
   logic        clk, srst, psel, penable, pwrite;
   logic [31:0] paddr, pwdata, prdata, rdData;
   logic        pready, pslverr, matchIrq, wakeup, rdErr;
   logic        waitMode, stop2Mode, stop3Mode, debugActive;
   logic [2:0]  srcClk;
   int          errors, n_checks;
   localparam logic [31:0] CTL = 32'(`PWC_OFS_STATUS_CONTROL);
   localparam logic [31:0] CNT = 32'(`PWC_OFS_COUNT_VALUE);
   localparam logic [31:0] LIM = 32'(`PWC_OFS_MATCH_LIMIT);

   periodic_wakeup_counter i_dut (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lowPowerOscClock(srcClk[0]), .externalRefClock(srcClk[1]),
      .internalRefClock(srcClk[2]), .waitMode(waitMode), .stop2Mode(stop2Mode),
      .stop3Mode(stop3Mode), .debugActive(debugActive), .matchIrq(matchIrq),
      .wakeup(wakeup)
   );

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Holds the request until pready is seen high; bounded wait
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      `CHK(pready, 1'b1);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdc(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rdData, e);
   endtask

   // Each pulse stays high and low for three clk cycles, enough for the synchroniser
   task tick(input int b, input int n);
      repeat (n) begin
         @(posedge clk);
         srcClk[b] <= 1'b1;
         repeat (3) @(posedge clk);
         srcClk[b] <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (5) @(posedge clk);
   endtask

   function automatic logic [31:0] ctl(input logic [1:0] s, input logic ie, input logic [3:0] ps);
      return {24'h0, 1'b0, s, ie, ps};
   endfunction

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      rdc(CTL, 32'h0);
      rdc(CNT, 32'h0);
      rdc(LIM, 32'h0);
      wr(LIM, 32'hA5);
      rdc(LIM, 32'hA5);
      wr(CNT, 32'h33);
      rdc(CNT, 32'h0);
      apb(1'b0, 32'hC, 32'h0);
      `CHK(rdErr, 1'b1);
      wr(CTL, ctl(2'h3, 1'b1, 4'hF));
      rdc(CTL, 32'h7F);
      wr(CTL, 32'h0);
      $display("test regs done");
   endtask

   task t_match;
      wr(LIM, 32'h2);
      wr(CTL, ctl(2'h0, 1'b0, 4'h8));
      tick(0, 2);
      rdc(CNT, 32'h2);
      tick(0, 1);
      rdc(CNT, 32'h0);
      rdc(CTL, 32'h88);
      `CHK(matchIrq, 1'b0);
      wr(CTL, ctl(2'h0, 1'b1, 4'h8));
      rdc(CTL, 32'h98);
      `CHK(matchIrq, 1'b1);
      `CHK(wakeup, 1'b0);
      @(posedge clk);
      waitMode <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK(wakeup, 1'b1);
      waitMode <= 1'b0;
      wr(CTL, 32'h98);
      rdc(CTL, 32'h18);
      `CHK(matchIrq, 1'b0);
      wr(LIM, 32'h0);
      tick(0, 1);
      rdc(CTL, 32'h98);
      wr(CTL, 32'h98);
      tick(0, 1);
      rdc(CTL, 32'h98);
      wr(CTL, 32'h88);
      $display("test match done");
   endtask

   task t_div;
      wr(LIM, 32'hFF);
      wr(CTL, ctl(2'h0, 1'b0, 4'h1));
      tick(0, 7);
      rdc(CNT, 32'h0);
      tick(0, 1);
      rdc(CNT, 32'h1);
      wr(CTL, ctl(2'h0, 1'b0, 4'h9));
      rdc(CNT, 32'h0);
      tick(0, 1);
      rdc(CNT, 32'h0);
      tick(0, 1);
      rdc(CNT, 32'h1);
      wr(CTL, ctl(2'h0, 1'b0, 4'h0));
      tick(0, 2);
      rdc(CNT, 32'h0);
      wr(CTL, ctl(2'h1, 1'b0, 4'h8));
      tick(1, 999);
      rdc(CNT, 32'h0);
      tick(1, 1);
      rdc(CNT, 32'h1);
      $display("test divide done");
   endtask

   task t_src;
      // Internal clock stays idle until after it is selected
      wr(CTL, ctl(2'h2, 1'b0, 4'h8));
      rdc(CNT, 32'h0);
      @(posedge clk);
      stop2Mode <= 1'b1;
      tick(2, 2);
      rdc(CNT, 32'h0);
      stop2Mode <= 1'b0;
      stop3Mode <= 1'b1;
      tick(2, 1);
      rdc(CNT, 32'h1);
      stop3Mode <= 1'b0;
      tick(0, 1);
      tick(1, 1);
      rdc(CNT, 32'h1);
      tick(2, 1);
      rdc(CNT, 32'h2);
      // Source 11 also takes the internal clock, through the second table
      wr(CTL, ctl(2'h3, 1'b0, 4'h8));
      rdc(CNT, 32'h0);
      tick(2, 1000);
      rdc(CNT, 32'h1);
      wr(CTL, ctl(2'h0, 1'b0, 4'h8));
      @(posedge clk);
      stop2Mode <= 1'b1;
      tick(0, 1);
      rdc(CNT, 32'h1);
      stop2Mode <= 1'b0;
      debugActive <= 1'b1;
      tick(0, 2);
      rdc(CNT, 32'h1);
      debugActive <= 1'b0;
      tick(0, 1);
      rdc(CNT, 32'h2);
      wr(LIM, 32'hFF);
      rdc(CNT, 32'h0);
      $display("test source done");
   endtask

   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      // Two thousand-tick runs dominate; ample margin
      repeat (60000) @(posedge clk);
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end_sim();
   end

   initial begin
      errors = 0;
      n_checks = 0;
      srst = 1'b1;
      {psel, penable, pwrite} = 3'h0;
      paddr = 32'h0;
      pwdata = 32'h0;
      srcClk = 3'h0;
      {waitMode, stop2Mode, stop3Mode, debugActive} = 4'h0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_match();
      t_div();
      t_src();
      end_sim();
   end
endmodule
